/* hw/pcl_host.sv */
`timescale 1ns/1ps
// Loading host end: pulses the request, waits, then streams buffered words.
module pcl_host import pcl_pkg::*; #(
	parameter int CF2CK_WAIT = CF2CK_CYC,
	parameter bit MON_STATUS = 1'b1
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic start,
	input wire logic hold_off,
	input wire logic [RATIO_W-1:0] ratio,
	input wire logic secure_on,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	output logic busy,
	output logic loaded,
	pcl_link_if.host link
);
	logic sts_m;
	logic sts_s;
	logic dn_m;
	logic dn_s;
	logic [DATA_W-1:0] f_data;
	logic f_valid;
	logic f_ready;
	logic [RATIO_W-1:0] rat;
	pcl_host_st_t st_q;
	pcl_host_st_t st_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [3:0] div_q;
	logic [3:0] div_d;
	logic [RATIO_W-1:0] rep_q;
	logic [RATIO_W-1:0] rep_d;
	logic [DATA_W-1:0] dat_q;
	logic [DATA_W-1:0] dat_d;
	logic doe_b_q;
	logic doe_b_d;
	logic req_b_q;
	logic req_b_d;
	logic cclk_q;
	logic cclk_d;
	logic hold_q;
	logic hold_d;
	logic [1:0] uc_q;
	logic [1:0] uc_d;
	logic uclk_q;
	logic uclk_d;

	// Words from the user wait here; a stalled link fills it and drops wr_ready.
	pcl_fifo #(
		.W(DATA_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_data(wr_data),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);

	// Status and done arrive from the device's pins.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sts_m <= 1'b0;
			sts_s <= 1'b0;
			dn_m <= 1'b0;
			dn_s <= 1'b0;
		end else begin
			sts_m <= link.status_line;
			sts_s <= sts_m;
			dn_m <= link.cfg_done;
			dn_s <= dn_m;
		end
	end

	// Compressed or secured streams need at least two clocks per word.
	always_comb begin
		if (secure_on && (ratio < RATIO_W'(2))) begin
			rat = RATIO_W'(2);
		end else if (ratio == '0) begin
			rat = RATIO_W'(1);
		end else begin
			rat = ratio;
		end
	end

	// The link clock is a divided system clock, so the host never needs a second domain.
	// With CFG_DIV of 8 it runs at 1.25 MHz, well under either width's limit.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		div_d = div_q;
		rep_d = rep_q;
		dat_d = dat_q;
		doe_b_d = doe_b_q;
		req_b_d = 1'b1;
		hold_d = 1'b0;
		f_ready = 1'b0;
		case (st_q)
			HS_IDLE, HS_DONE: begin
				if (start) begin
					st_d = HS_PULSE;
					cnt_d = '0;
					req_b_d = 1'b0;
				end
			end
			HS_PULSE: begin
				req_b_d = 1'b0;
				if (cnt_q == CNT_W'(CFG_LOW_CYC - 1)) begin
					st_d = HS_WAIT;
					cnt_d = '0;
					req_b_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			HS_WAIT: begin
				// The user may hold the status line low to postpone loading.
				hold_d = hold_off;
				if (MON_STATUS) begin
					if (sts_s && !hold_off) begin
						st_d = HS_GAP;
						cnt_d = '0;
					end
				end else if (cnt_q == CNT_W'(CF2CK_WAIT - 1)) begin
					st_d = HS_STREAM;
					div_d = '0;
					rep_d = '0;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			HS_GAP: begin
				if (cnt_q == CNT_W'(ST2CK_CYC - 1)) begin
					st_d = HS_STREAM;
					div_d = '0;
					rep_d = '0;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			HS_STREAM: begin
				if (div_q != '0) begin
					div_d = (div_q == 4'(CFG_DIV - 1)) ? '0 : div_q + 1'b1;
				end else if (dn_s) begin
					// Done seen while the clock is low: stop and float the bus.
					st_d = HS_DONE;
					doe_b_d = 1'b1;
				end else if (rep_q != '0) begin
					rep_d = rep_q - 1'b1;
					div_d = div_q + 1'b1;
				end else if (f_valid) begin
					f_ready = 1'b1;
					dat_d = f_data;
					doe_b_d = 1'b0;
					rep_d = rat - 1'b1;
					div_d = div_q + 1'b1;
				end
				// With no word ready the clock simply waits low: a stall, not a gap.
			end
			default: begin
			end
		endcase
	end

	// Clock high for the second half of each divider round.
	always_comb begin
		cclk_d = (st_d == HS_STREAM) && (div_d >= 4'(CFG_DIV / 2));
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= HS_IDLE;
			cnt_q <= '0;
			div_q <= '0;
			rep_q <= '0;
			dat_q <= '0;
			doe_b_q <= 1'b1;
			req_b_q <= 1'b1;
			cclk_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			div_q <= div_d;
			rep_q <= rep_d;
			dat_q <= dat_d;
			doe_b_q <= doe_b_d;
			req_b_q <= req_b_d;
			cclk_q <= cclk_d;
			hold_q <= hold_d;
		end
	end

	// Free-running user initialisation clock for the device.
	always_comb begin
		if (uc_q == 2'(UCLK_HALF - 1)) begin
			uc_d = '0;
			uclk_d = ~uclk_q;
		end else begin
			uc_d = uc_q + 1'b1;
			uclk_d = uclk_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			uc_q <= '0;
			uclk_q <= 1'b0;
		end else begin
			uc_q <= uc_d;
			uclk_q <= uclk_d;
		end
	end

	assign link.cfg_req_b = req_b_q;
	assign link.cfg_clock = cclk_q;
	assign link.cfg_data = dat_q;
	assign link.data_oe_b = doe_b_q;
	assign link.user_init_clock = uclk_q;
	assign link.st_host_o = 1'b0;
	assign link.st_host_oe_b = ~hold_q;
	assign busy = (st_q != HS_IDLE) && (st_q != HS_DONE);
	assign loaded = (st_q == HS_DONE);
endmodule : pcl_host

/* hw/pcl_pkg.sv */
package pcl_pkg;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 16;
	localparam int RATIO_W = 4;
	localparam int CNT_W = 16;
	// System clock rate in kHz, used to turn times into cycle counts.
	localparam int SYS_KHZ = 10000;
	localparam int T_CFG_LOW_US = 2;
	localparam int CFG_LOW_CYC = (T_CFG_LOW_US * SYS_KHZ + 999) / 1000;
	localparam int T_STATUS_MIN_US = 268;
	localparam int ST_LOW_CYC = (T_STATUS_MIN_US * SYS_KHZ + 999) / 1000;
	localparam int T_ST2CK_US = 2;
	localparam int ST2CK_CYC = (T_ST2CK_US * SYS_KHZ + 999) / 1000;
	localparam int T_CF2CK_US = 1506;
	localparam int CF2CK_CYC = (T_CF2CK_US * SYS_KHZ + 999) / 1000;
	localparam int T_CD2UM_MIN_US = 175;
	localparam int CD2UM_CYC = (T_CD2UM_MIN_US * SYS_KHZ + 999) / 1000;
	// Four periods of the fastest allowed link clock (10 ns).
	localparam int T_CFGCLK_MIN_NS = 10;
	localparam int CD2CU_PERIODS = 4;
	localparam int CD2CU_RAW = (CD2CU_PERIODS * T_CFGCLK_MIN_NS * SYS_KHZ + 999999) / 1000000;
	localparam int CD2CU_CYC = (CD2CU_RAW < 1) ? 1 : CD2CU_RAW;
	localparam int USER_INIT_CYCLES = 8576;
	// Divider for the link clock; 10 MHz / 8 is far below either limit.
	localparam int CFG_DIV = 8;
	localparam int UCLK_HALF = 2;
	localparam int RST_WORDS = 64;

	typedef enum logic [2:0] {
		DS_CLEAR, DS_WAIT_EXT, DS_LOAD, DS_INIT, DS_UWAIT, DS_UCNT, DS_USER
	} pcl_dev_st_t;

	typedef enum logic [2:0] {
		HS_IDLE, HS_PULSE, HS_WAIT, HS_GAP, HS_STREAM, HS_DONE
	} pcl_host_st_t;
endpackage : pcl_pkg

/* hw/pcl_link_if.sv */
`timescale 1ns/1ps
// Board-level wiring between the loading host and the configurable device.
interface pcl_link_if import pcl_pkg::*; ();
	logic cfg_req_b;
	logic cfg_clock;
	logic [DATA_W-1:0] cfg_data;
	logic data_oe_b;
	logic user_init_clock;
	logic cfg_done;
	logic st_dev_o;
	logic st_dev_oe_b;
	logic st_host_o;
	logic st_host_oe_b;
	logic status_line;

	// Open-drain status: low if either party pulls it low, pulled up otherwise.
	assign status_line = ~((~st_dev_oe_b & ~st_dev_o) | (~st_host_oe_b & ~st_host_o));

	modport dev (
		input cfg_req_b, cfg_clock, cfg_data, data_oe_b, user_init_clock, status_line,
		output cfg_done, st_dev_o, st_dev_oe_b
	);
	modport host (
		output cfg_req_b, cfg_clock, cfg_data, data_oe_b, user_init_clock, st_host_o, st_host_oe_b,
		input cfg_done, status_line
	);
endinterface : pcl_link_if

/* hw/pcl_fifo.sv */
`timescale 1ns/1ps
// Synchronous flip-flop FIFO with valid/ready on both sides.
module pcl_fifo #(
	parameter int W = 32,
	parameter int D = 16
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d;
	logic push, pop;

	// Extra pointer bit tells full from empty when the indexes meet.
	assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_q != rd_q;
	assign out_data = mem_q[rd_q[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointer advance.
	always_comb begin
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// Storage has no reset; only written slots are ever read.
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end
endmodule : pcl_fifo

/* hw/pcl_dev.sv */
`timescale 1ns/1ps
// Configurable-device end: clears, gates, captures words, then initialises.
module pcl_dev import pcl_pkg::*; #(
	parameter int LOAD_WORDS = RST_WORDS,
	parameter int USER_INIT_CYC = USER_INIT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cfg_use_uclk,
	input wire logic [RATIO_W-1:0] cfg_ratio,
	output logic [DATA_W-1:0] word_data,
	output logic word_valid,
	output logic loading,
	output logic user_mode,
	pcl_link_if.dev link
);
	logic crst_b;
	logic [DATA_W-1:0] cap_q, cap_d;
	logic tog_q, tog_d;
	logic req_m, req_s, sts_m, sts_s;
	logic tog_m, tog_s, tog_p, uck_m, uck_s, uck_p;
	logic wpulse, urise;
	logic [RATIO_W-1:0] rat;
	pcl_dev_st_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, wcnt_q, wcnt_d;
	logic [RATIO_W-1:0] ph_q, ph_d;
	logic [DATA_W-1:0] wd_d;
	logic wv_d, done_q, done_d, soe_b_q, soe_b_d;

	// Link-domain logic is cleared while the request is low; the clock is idle then.
	assign crst_b = rst_b & link.cfg_req_b;

	// Every rising link edge latches the bus and flips a toggle for the crossing.
	always_comb begin
		cap_d = link.cfg_data;
		tog_d = ~tog_q;
	end

	always_ff @(posedge link.cfg_clock or negedge crst_b) begin
		if (!crst_b) begin
			cap_q <= '0;
			tog_q <= 1'b0;
		end else begin
			cap_q <= cap_d;
			tog_q <= tog_d;
		end
	end

	// Pin and cross-domain synchronisers; the toggle's third stage finds edges.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			req_m <= 1'b0;
			req_s <= 1'b0;
			sts_m <= 1'b0;
			sts_s <= 1'b0;
			tog_m <= 1'b0;
			tog_s <= 1'b0;
			tog_p <= 1'b0;
			uck_m <= 1'b0;
			uck_s <= 1'b0;
			uck_p <= 1'b0;
		end else begin
			req_m <= link.cfg_req_b;
			req_s <= req_m;
			sts_m <= link.status_line;
			sts_s <= sts_m;
			tog_m <= tog_q;
			tog_s <= tog_m;
			tog_p <= tog_s;
			uck_m <= link.user_init_clock;
			uck_s <= uck_m;
			uck_p <= uck_s;
		end
	end

	// The captured word stays put for several system cycles, so it is read
	// only after the toggle has settled through two stages.
	assign wpulse = tog_s ^ tog_p;
	assign urise = uck_s & ~uck_p;
	assign rat = (cfg_ratio == '0) ? RATIO_W'(1) : cfg_ratio;

	// Main sequence: clear, release, wait for the line, load, initialise.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		wcnt_d = wcnt_q;
		ph_d = ph_q;
		wd_d = word_data;
		wv_d = 1'b0;
		case (st_q)
			DS_CLEAR: begin
				if (cnt_q < CNT_W'(ST_LOW_CYC - 1)) begin
					cnt_d = cnt_q + 1'b1;
				end else if (req_s) begin
					st_d = DS_WAIT_EXT;
				end
			end
			DS_WAIT_EXT: begin
				if (sts_s) begin
					st_d = DS_LOAD;
					wcnt_d = '0;
					ph_d = '0;
				end
			end
			DS_LOAD: begin
				if (wpulse) begin
					// Repeated edges of one word are skipped by the phase count.
					if (ph_q == '0) begin
						wd_d = cap_q;
						wv_d = 1'b1;
						wcnt_d = wcnt_q + 1'b1;
						if (wcnt_q == CNT_W'(LOAD_WORDS - 1)) begin
							st_d = DS_INIT;
							cnt_d = '0;
						end
					end
					ph_d = (ph_q + 1'b1 >= rat) ? '0 : ph_q + 1'b1;
				end
			end
			DS_INIT: begin
				if (cfg_use_uclk) begin
					st_d = DS_UWAIT;
					cnt_d = '0;
				end else if (cnt_q == CNT_W'(CD2UM_CYC - 1)) begin
					st_d = DS_USER;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			DS_UWAIT: begin
				if (cnt_q == CNT_W'(CD2CU_CYC - 1)) begin
					st_d = DS_UCNT;
					cnt_d = '0;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			DS_UCNT: begin
				if (urise) begin
					if (cnt_q == CNT_W'(USER_INIT_CYC - 1)) begin
						st_d = DS_USER;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
			end
			default: begin
			end
		endcase
		// A low request aborts anything, including user mode.
		if (!req_s) begin
			st_d = DS_CLEAR;
			cnt_d = '0;
		end
		done_d = (st_d == DS_INIT) || (st_d == DS_UWAIT) || (st_d == DS_UCNT) || (st_d == DS_USER);
		soe_b_d = (st_d != DS_CLEAR);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= DS_CLEAR;
			cnt_q <= '0;
			wcnt_q <= '0;
			ph_q <= '0;
			word_data <= '0;
			word_valid <= 1'b0;
			done_q <= 1'b0;
			soe_b_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wcnt_q <= wcnt_d;
			ph_q <= ph_d;
			word_data <= wd_d;
			word_valid <= wv_d;
			done_q <= done_d;
			soe_b_q <= soe_b_d;
		end
	end

	assign link.st_dev_o = 1'b0;
	assign link.st_dev_oe_b = soe_b_q;
	assign link.cfg_done = done_q;
	assign loading = (st_q == DS_LOAD);
	assign user_mode = (st_q == DS_USER);
endmodule : pcl_dev

/* bench/pcl_link_props.sv */
`timescale 1ns/1ps
// Watches the board wires between the loading host and the device.
module pcl_link_props import pcl_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cfg_req_b,
	input wire logic cfg_clock,
	input wire logic [DATA_W-1:0] cfg_data,
	input wire logic data_oe_b,
	input wire logic cfg_done,
	input wire logic st_host_oe_b,
	input wire logic status_line
);
	int low_q, low_d, high_q, high_d, rel_q, rel_d;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Run lengths of the status line; a counter is cheaper than long repetitions.
	always_comb begin
		low_d = status_line ? 0 : low_q + 1;
		high_d = status_line ? high_q + 1 : 0;
		rel_d = (cfg_req_b && !status_line && st_host_oe_b) ? rel_q + 1 : 0;
	end

	// Registers the counts; cleared in reset so a restart never sees stale lengths.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			low_q <= 0;
			high_q <= 0;
			rel_q <= 0;
		end else begin
			low_q <= low_d;
			high_q <= high_d;
			rel_q <= rel_d;
		end
	end

	property p_done_low;
		$fell(cfg_req_b) |-> ##[0:6] !cfg_done;
	endproperty
	a_done_low: assert property (p_done_low) else $error("done not low in time");
	property p_st_low;
		$fell(cfg_req_b) |-> ##[0:6] !status_line;
	endproperty
	a_st_low: assert property (p_st_low) else $error("status not low in time");
	property p_req_width;
		$rose(cfg_req_b) |-> !$past(cfg_req_b, 20);
	endproperty
	a_req_width: assert property (p_req_width) else $error("request pulse short");
	property p_st_min;
		$rose(status_line) |-> low_q >= ST_LOW_CYC;
	endproperty
	a_st_min: assert property (p_st_min) else $error("status low pulse short");
	property p_st_max;
		rel_q <= CF2CK_CYC;
	endproperty
	a_st_max: assert property (p_st_max) else $error("status release late");
	property p_first_clk;
		$rose(cfg_clock) |-> high_q >= ST2CK_CYC;
	endproperty
	a_first_clk: assert property (p_first_clk) else $error("clock too soon after status");
	property p_data_hold;
		$rose(cfg_clock) |-> $stable(cfg_data) && !data_oe_b;
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved at capture");
	property p_release;
		$rose(cfg_done) |-> ##[1:20] data_oe_b;
	endproperty
	a_release: assert property (p_release) else $error("data bus not released");

	c_done: cover property ($rose(cfg_done));
	c_hold: cover property (!st_host_oe_b && !status_line);
	c_restart: cover property ($rose(cfg_req_b));
endmodule : pcl_link_props

/* bench/testbench.sv */
`timescale 1ns/1ps
// Loads four bitstreams back to back through both ends and checks each word.
module testbench import pcl_pkg::*;;
	// Short counts keep the run brief; expectations derive from them.
	localparam int LW = 4;
	localparam int UI = 8;
	localparam int UCP = 2 * UCLK_HALF;
	logic clk_sys, rst_b, start, hold_off, secure_on, wr_valid, wr_ready, busy, loaded;
	logic cfg_use_uclk, word_valid, loading, user_mode;
	logic [RATIO_W-1:0] ratio, cfg_ratio;
	logic [DATA_W-1:0] wr_data, word_data;
	logic [31:0] seed;
	logic [DATA_W-1:0] exp_q[$];
	int fails, n_compared, n_words, i;

	pcl_link_if link();
	pcl_host #(.CF2CK_WAIT(30)) pcl_host_i (.clk_sys, .rst_b, .start, .hold_off, .ratio, .secure_on,
		.wr_data, .wr_valid, .wr_ready, .busy, .loaded, .link(link));
	pcl_dev #(.LOAD_WORDS(LW), .USER_INIT_CYC(UI)) pcl_dev_i (.clk_sys, .rst_b, .cfg_use_uclk, .cfg_ratio,
		.word_data, .word_valid, .loading, .user_mode, .link(link));
	pcl_link_props pcl_link_props_i (.clk_sys, .rst_b, .cfg_req_b(link.cfg_req_b), .cfg_clock(link.cfg_clock),
		.cfg_data(link.cfg_data), .data_oe_b(link.data_oe_b), .cfg_done(link.cfg_done),
		.st_host_oe_b(link.st_host_oe_b), .status_line(link.status_line));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want, input string what);
		n_compared++;
		if (seen !== want) begin
			fails++;
			$display("ERROR at %0t ns: %s seen %h expected %h", $time, what, seen, want);
		end
	endtask : check

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// Writes one word into the host buffer and records it in the model.
	task automatic push(input logic [DATA_W-1:0] w);
		int k;
		@(posedge clk_sys);
		wr_data <= w;
		wr_valid <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(negedge clk_sys);
			if (wr_ready === 1'b1) break;
		end
		check(32'(wr_ready), 1, "push accepted");
		exp_q.push_back(w);
		@(posedge clk_sys);
		wr_valid <= 1'b0;
	endtask : push

	// One configuration; each run after the first also aborts user mode.
	task automatic run_cfg(input logic [RATIO_W-1:0] r, input logic sec, input logic uclk, input int hold);
		int cyc;
		logic [RATIO_W-1:0] eff;
		eff = (r == 4'h0) ? 4'h1 : r;
		if (sec && eff < 4'h2) eff = 4'h2;
		n_words = 0;
		@(posedge clk_sys);
		ratio <= r;
		secure_on <= sec;
		cfg_ratio <= eff;
		cfg_use_uclk <= uclk;
		hold_off <= (hold > 0);
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		repeat (8) @(negedge clk_sys);
		check(32'(user_mode), 0, "abort");
		check(32'(busy), 1, "host busy");
		if (hold > 0) begin
			repeat (ST_LOW_CYC + hold) @(negedge clk_sys);
			check(32'(loading), 0, "postponed");
			@(posedge clk_sys);
			hold_off <= 1'b0;
		end
		for (cyc = 0; cyc < 20000 && link.cfg_done !== 1'b1; cyc++) @(negedge clk_sys);
		check(32'(link.cfg_done), 1, "done seen");
		for (cyc = 0; cyc < 6000 && user_mode !== 1'b1; cyc++) @(negedge clk_sys);
		if (uclk) check(32'(cyc >= (UI - 1) * UCP && cyc <= UI * UCP + 24), 1, "user clock init");
		else check(32'(cyc >= CD2UM_CYC && cyc <= 4370), 1, "oscillator init");
		check(32'(n_words), 32'(LW), "word count");
		check(32'(link.data_oe_b), 1, "bus released");
		check(32'(loaded), 1, "host loaded");
		// With one clock per word, done reaches the host only after it has clocked out one more word.
		// The device ignores that word, so the model drops it as well.
		if (eff == 4'h1 && exp_q.size() > 0) void'(exp_q.pop_front());
		$display("test done: ratio %0d words %0d", eff, n_words);
	endtask : run_cfg

	// Clock at 10 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Every captured word must be the next one written, in order.
	always @(negedge clk_sys) begin
		if (word_valid === 1'b1) begin
			n_words++;
			check(word_data, exp_q.size() ? exp_q.pop_front() : 'x, "word");
		end
	end

	// Cuts a hang short; a normal run needs about 15000 cycles.
	initial begin
		repeat (60000) @(posedge clk_sys);
		fails++;
		$display("ERROR at %0t ns: watchdog expired", $time);
		wrap_up();
	end

	// Fill the buffer until it refuses, then drain it over four loads.
	initial begin
		rst_b = 1'b0;
		start = 1'b0;
		hold_off = 1'b0;
		ratio = 4'h1;
		secure_on = 1'b0;
		wr_data = 32'h0;
		wr_valid = 1'b0;
		cfg_use_uclk = 1'b0;
		cfg_ratio = 4'h1;
		fails = 0;
		n_compared = 0;
		n_words = 0;
		seed = 32'h8cab;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		for (i = 0; i < FIFO_DEPTH; i++) push(rnd());
		@(negedge clk_sys);
		check(32'(wr_ready), 0, "buffer full");
		run_cfg(4'h1, 1'b0, 1'b0, 0);
		// One more word replaces the one that the first load clocks out after done.
		push(rnd());
		run_cfg(4'h3, 1'b0, 1'b1, 50 + int'(rnd() % 64));
		run_cfg(4'h0, 1'b1, 1'b0, 0);
		run_cfg(4'h4, 1'b1, 1'b1, 0);
		@(negedge clk_sys);
		check(32'(wr_ready), 1, "buffer drained");
		check(32'(exp_q.size()), 0, "words left");
		wrap_up();
	end
endmodule : testbench
